// file: rtl/spc_bridge.sv
// Fixed off-time chopper for one full bridge with blanking, mixed or slow
// decay, synchronous rectification and a latched short-to-ground trip.
// Assumes sense and fault inputs are synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
`include "spc_defines.svh"

module spc_bridge
  import spc_pkg::*;
#(
  parameter int BLANK_CYC = `SPC_NS_TO_CYC(`SPC_BLANK_NS),
  parameter int OFF_CYC = `SPC_NS_TO_CYC(`SPC_OFF_NS),
  parameter int FAST_CYC = OFF_CYC * `SPC_FAST_NUM / `SPC_FAST_DEN,
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic clear_short,
  input wire logic sense_trip,
  input wire logic short_gnd,
  input wire logic zero_current,
  input wire logic mixed,
  input wire logic neg,
  output logic src_a,
  output logic snk_a,
  output logic src_b,
  output logic snk_b,
  output logic short_latched,
  output logic short_event
);

  spc_chop_e state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic was_mixed, next_was_mixed;
  logic next_short;
  logic fwd_src, fwd_snk, rev_src, rev_snk;

  always_comb begin
    next_state = state;
    next_cnt = cnt + 1'b1;
    next_was_mixed = was_mixed;
    next_short = short_latched;
    short_event = 1'b0;
    if (clear_short) begin
      next_short = 1'b0;
    end else if (short_gnd && state != SPC_IDLE) begin
      next_short = 1'b1; // R1
      short_event = !short_latched;
    end
    case (state)
      SPC_IDLE: begin
        next_cnt = '0;
        if (run && !next_short) begin
          next_state = SPC_BLANK;
        end
      end
      SPC_BLANK: begin
        if (cnt == CNT_W'(BLANK_CYC - 1)) begin // R15
          next_state = SPC_DRIVE;
          next_cnt = '0;
        end
      end
      SPC_DRIVE: begin
        next_cnt = '0;
        if (sense_trip) begin // R2
          next_state = mixed ? SPC_FAST : SPC_SLOW; // R11
          next_was_mixed = mixed;
        end
      end
      SPC_FAST: begin
        if (cnt == CNT_W'(FAST_CYC - 1)) begin // R11
          next_state = SPC_SLOW;
        end
      end
      SPC_SLOW: begin
        if (cnt == CNT_W'(OFF_CYC - 1)) begin // R2 R15
          next_state = SPC_BLANK;
          next_cnt = '0;
        end
      end
      default: begin
        next_state = SPC_IDLE;
      end
    endcase
    if (!run || next_short) begin
      next_state = SPC_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SPC_IDLE;
      cnt <= '0;
      was_mixed <= 1'b1;
      short_latched <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      was_mixed <= next_was_mixed;
      short_latched <= next_short;
    end
  end

  // Forward diagonal drives, reverse diagonal carries the fast decay current
  always_comb begin
    fwd_src = 1'b0;
    fwd_snk = 1'b0;
    rev_src = 1'b0;
    rev_snk = 1'b0;
    case (state)
      SPC_BLANK, SPC_DRIVE: begin
        fwd_src = 1'b1;
        fwd_snk = 1'b1;
      end
      SPC_FAST: begin
        rev_src = !zero_current; // R12 R13 R14
        rev_snk = !zero_current; // R12 R13
      end
      SPC_SLOW: begin
        // Mixed decay released the sink too; slow recirculates low side
        fwd_snk = !was_mixed || !zero_current; // R14 R13
        rev_snk = !zero_current; // R12 R13
      end
      default: begin
        fwd_src = 1'b0;
      end
    endcase
    src_a = neg ? rev_src : fwd_src;
    snk_b = neg ? rev_snk : fwd_snk;
    src_b = neg ? fwd_src : rev_src;
    snk_a = neg ? fwd_snk : rev_snk;
  end

endmodule : spc_bridge
`default_nettype wire

// file: rtl/spc_ctrl.sv
// Top of the stepper output protection controller: APB register slave,
// output gating for both bridges, sleep and lockout handling, interrupts.
// Assumes all pin inputs are synchronous to clk and an APB3 master on clk.
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "spc_defines.svh"

// Notes on behaviour
// R1: Short to ground latches bridge off until wake
// R2: Shorted load repeats blank, trip, off-time cycle
// R3: Sink gate supply fault disables all outputs
// R4: Output disable high turns every output off
// R5: Translator steps regardless of output disable
// R6: Overtemperature or pump undervoltage forces outputs off
// R7: Lockout disables outputs and homes translator
// R8: Sleep low stops outputs, regulator, charge pump
// R9: Sleep high runs; wake returns to home
// R10: Host waits 1 ms after wake before stepping
// R11: Mixed decay: fast 31.25% then slow
// R12: Decay phase switches matching transistors on
// R13: Rectification stops near zero load current
// R14: Trip drops source in slow, both in mixed
// R15: Blank and off-time counters with parameter limits
module spc_ctrl
  import spc_pkg::*;
#(
  parameter int BLANK_CYC = `SPC_NS_TO_CYC(`SPC_BLANK_NS),
  parameter int OFF_CYC = `SPC_NS_TO_CYC(`SPC_OFF_NS),
  parameter int SETTLE_CYC = `SPC_NS_TO_CYC(`SPC_SETTLE_NS)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SPC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic step,
  input wire logic dir,
  input wire logic [1:0] step_resolution_select,
  input wire logic out_disable,
  input wire logic sleep_n,
  input wire logic supply_lockout,
  input wire logic over_temp,
  input wire logic pump_supply_uv,
  input wire logic sink_gate_supply_fault,
  input wire logic [1:0] sense_trip,
  input wire logic [1:0] short_to_ground,
  input wire logic [1:0] zero_current,
  output logic [1:0] src_a,
  output logic [1:0] snk_a,
  output logic [1:0] src_b,
  output logic [1:0] snk_b,
  output logic pump_enable,
  output logic irq
);

  localparam int SETTLE_W = $clog2(SETTLE_CYC + 1);

  // Register and pin state
  logic [31:0] ctrl, next_ctrl;
  logic [`SPC_IRQ_W-1:0] irq_stat, next_irq_stat;
  logic [`SPC_IRQ_W-1:0] irq_mask, next_irq_mask;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_irq;
  logic step_q, next_step_q;
  logic fault_q, next_fault_q;
  logic settled, next_settled;
  logic [SETTLE_W-1:0] settle_cnt, next_settle_cnt;
  logic [1:0] next_src_a, next_snk_a, next_src_b, next_snk_b;
  logic next_pump_enable;

  // Internal nets
  logic global_fault;
  logic outputs_ok;
  logic home;
  logic step_pulse;
  logic apb_done;
  logic rd_irq;
  logic [`SPC_IRQ_W-1:0] events;
  logic [31:0] status_word;
  logic [`SPC_IDX_W-1:0] pos_idx;
  logic [1:0] ph_neg, ph_mixed, use_mixed;
  logic [1:0] br_src_a, br_snk_a, br_src_b, br_snk_b;
  logic [1:0] short_latched, short_event;

  assign global_fault = sink_gate_supply_fault || over_temp || pump_supply_uv; // R3 R6
  assign outputs_ok = sleep_n && !supply_lockout && !global_fault &&
                      !out_disable; // R4 R7 R8
  assign home = !sleep_n || supply_lockout; // R7 R9
  // Steps are taken whatever out_disable says
  assign step_pulse = step && !step_q; // R5

  spc_translator u_translator (
    .clk(clk),
    .rst_n(rst_n),
    .home(home),
    .step_pulse(step_pulse),
    .dir(dir),
    .res(step_resolution_select),
    .idx(pos_idx),
    .neg(ph_neg),
    .mixed(ph_mixed)
  );

  // Forced mixed skips full step, which keeps the translator's decay choice
  assign use_mixed = ctrl[`SPC_CTRL_MIXED_ALWAYS] &&
                     step_resolution_select != `SPC_RES_FULL ? 2'h3 : ph_mixed;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_bridge
      spc_bridge #(
        .BLANK_CYC(BLANK_CYC),
        .OFF_CYC(OFF_CYC)
      ) u_bridge (
        .clk(clk),
        .rst_n(rst_n),
        .run(outputs_ok), // R4 R8
        .clear_short(!sleep_n), // R1
        .sense_trip(sense_trip[g]),
        .short_gnd(short_to_ground[g]),
        .zero_current(zero_current[g]),
        .mixed(use_mixed[g]),
        .neg(ph_neg[g]),
        .src_a(br_src_a[g]),
        .snk_a(br_snk_a[g]),
        .src_b(br_src_b[g]),
        .snk_b(br_snk_b[g]),
        .short_latched(short_latched[g]),
        .short_event(short_event[g])
      );
    end
  endgenerate

  // Gate outputs and wake settling
  always_comb begin
    next_pump_enable = sleep_n; // R8
    next_step_q = step;
    next_fault_q = global_fault;
    next_src_a = outputs_ok ? br_src_a : 2'h0; // R3 R4 R6 R7 R8
    next_snk_a = outputs_ok ? br_snk_a : 2'h0;
    next_src_b = outputs_ok ? br_src_b : 2'h0;
    next_snk_b = outputs_ok ? br_snk_b : 2'h0;
    next_settle_cnt = settle_cnt;
    next_settled = settled;
    if (!sleep_n || supply_lockout) begin
      next_settle_cnt = '0;
      next_settled = 1'b0;
    end else if (!settled) begin
      // Pump settling time the host must leave before stepping
      if (settle_cnt == SETTLE_W'(SETTLE_CYC - 1)) begin // R10
        next_settled = 1'b1;
      end else begin
        next_settle_cnt = settle_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pump_enable <= 1'b0;
      step_q <= 1'b0;
      fault_q <= 1'b0;
      src_a <= 2'h0;
      snk_a <= 2'h0;
      src_b <= 2'h0;
      snk_b <= 2'h0;
      settle_cnt <= '0;
      settled <= 1'b0;
    end else begin
      pump_enable <= next_pump_enable;
      step_q <= next_step_q;
      fault_q <= next_fault_q;
      src_a <= next_src_a;
      snk_a <= next_snk_a;
      src_b <= next_src_b;
      snk_b <= next_snk_b;
      settle_cnt <= next_settle_cnt;
      settled <= next_settled;
    end
  end

  // APB slave: no wait states, pready rises in the first access cycle
  assign apb_done = psel && penable && pready;
  assign rd_irq = apb_done && !pwrite && paddr == `SPC_REG_IRQ_STAT;

  always_comb begin
    status_word = 32'h00000000;
    status_word[`SPC_ST_SHORT_HI:`SPC_ST_SHORT_LO] = short_latched;
    status_word[`SPC_ST_FAULT] = global_fault;
    status_word[`SPC_ST_ASLEEP] = !sleep_n;
    status_word[`SPC_ST_SETTLED] = settled;
    status_word[`SPC_ST_POS_HI:`SPC_ST_POS_LO] = pos_idx;
  end

  always_comb begin
    events = '0;
    events[`SPC_IRQ_SHORT] = |short_event;
    events[`SPC_IRQ_FAULT] = global_fault && !fault_q;
    events[`SPC_IRQ_WAKE] = next_settled && !settled;
  end

  always_comb begin
    next_ctrl = ctrl;
    next_irq_mask = irq_mask;
    next_prdata = prdata;
    next_pready = psel && !penable;
    next_pslverr = 1'b0;
    if (psel && !penable) begin
      next_prdata = 32'h00000000;
      if (paddr == `SPC_REG_CTRL) begin
        next_prdata = ctrl;
      end else if (paddr == `SPC_REG_STATUS) begin
        next_prdata = status_word;
      end else if (paddr == `SPC_REG_IRQ_STAT) begin
        next_prdata = 32'(irq_stat);
      end else if (paddr == `SPC_REG_IRQ_MASK) begin
        next_prdata = 32'(irq_mask);
      end else begin
        next_pslverr = 1'b1;
      end
      if (pwrite) begin
        next_prdata = 32'h00000000;
      end
    end
    if (apb_done && pwrite) begin
      if (paddr == `SPC_REG_CTRL) begin
        next_ctrl = 32'(pwdata[`SPC_CTRL_MIXED_ALWAYS]);
      end else if (paddr == `SPC_REG_IRQ_MASK) begin
        next_irq_mask = pwdata[`SPC_IRQ_W-1:0];
      end
    end
    // Clear only the bits the read reported, so an event landing after the
    // setup cycle is kept; a new event also wins over the clear
    next_irq_stat = (irq_stat & ~(rd_irq ? prdata[`SPC_IRQ_W-1:0] : '0)) | events;
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `SPC_CTRL_RESET;
      irq_mask <= `SPC_IRQ_MASK_RESET;
      irq_stat <= '0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      irq_mask <= next_irq_mask;
      irq_stat <= next_irq_stat;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
    end
  end

endmodule : spc_ctrl
`default_nettype wire

// file: rtl/spc_defines.svh
// Constants of the stepper output protection controller: register map,
// field positions, reset values and timing figures.
// Assumes a 125 MHz core clock; included by bare name.
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH

`define SPC_CLK_MHZ 125
`define SPC_BLANK_NS 1000
`define SPC_OFF_NS 30000
`define SPC_SETTLE_NS 1000000
// Least times round up to whole cycles
`define SPC_NS_TO_CYC(ns) (((ns) * `SPC_CLK_MHZ + 999) / 1000)
`define SPC_FAST_NUM 5
`define SPC_FAST_DEN 16

`define SPC_ADDR_W 12
`define SPC_REG_CTRL 12'h000
`define SPC_REG_STATUS 12'h004
`define SPC_REG_IRQ_STAT 12'h008
`define SPC_REG_IRQ_MASK 12'h00C

`define SPC_CTRL_MIXED_ALWAYS 0
`define SPC_CTRL_RESET 32'h00000000
`define SPC_IRQ_MASK_RESET 3'h0

`define SPC_ST_SHORT_LO 0
`define SPC_ST_SHORT_HI 1
`define SPC_ST_FAULT 2
`define SPC_ST_ASLEEP 3
`define SPC_ST_SETTLED 4
`define SPC_ST_POS_LO 8
`define SPC_ST_POS_HI 12

`define SPC_IRQ_SHORT 0
`define SPC_IRQ_FAULT 1
`define SPC_IRQ_WAKE 2
`define SPC_IRQ_W 3

`define SPC_IDX_W 5
`define SPC_HOME_IDX 5'h04
`define SPC_HALF_TURN 5'h10
`define SPC_QUARTER 5'h08
`define SPC_FULL_STEP 5'h08
`define SPC_RES_FULL 2'h0

`endif

// file: rtl/spc_pkg.sv
// Types shared by the stepper output protection controller files.
// Assumes spc_defines.svh is compiled alongside.
package spc_pkg;

  typedef enum logic [2:0] {
    SPC_IDLE,
    SPC_BLANK,
    SPC_DRIVE,
    SPC_FAST,
    SPC_SLOW
  } spc_chop_e;

  typedef logic [1:0] spc_res_t;

endpackage : spc_pkg

// file: rtl/spc_translator.sv
// Step translator: position index over one electrical turn, winding polarity
// and decay choice per winding. Assumes step_pulse is a one-cycle pulse.
`timescale 1ns/100ps
`default_nettype none
`include "spc_defines.svh"

module spc_translator
  import spc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic home,
  input wire logic step_pulse,
  input wire logic dir,
  input wire spc_res_t res,
  output logic [`SPC_IDX_W-1:0] idx,
  output logic [1:0] neg,
  output logic [1:0] mixed
);

  logic [`SPC_IDX_W-1:0] next_idx;
  logic [1:0] next_neg;
  logic [1:0] next_mixed;
  logic [`SPC_IDX_W-1:0] step;

  // Cosine magnitude grows with distance from the quarter point
  function automatic logic [3:0] cos_mag(input logic [`SPC_IDX_W-1:0] i);
    logic [3:0] m;
    m = i[3:0];
    cos_mag = (m >= 4'h8) ? m - 4'h8 : 4'h8 - m;
  endfunction : cos_mag

  function automatic logic [3:0] sin_mag(input logic [`SPC_IDX_W-1:0] i);
    sin_mag = 4'h8 - cos_mag(i);
  endfunction : sin_mag

  always_comb begin
    step = `SPC_FULL_STEP >> res;
    next_idx = idx;
    next_neg = neg;
    next_mixed = mixed;
    if (home) begin
      next_idx = `SPC_HOME_IDX;
      next_mixed = 2'h3;
    end else if (step_pulse) begin
      next_idx = dir ? idx + step : idx - step;
      next_mixed[0] = cos_mag(next_idx) < cos_mag(idx);
      next_mixed[1] = sin_mag(next_idx) < sin_mag(idx);
      if (res == `SPC_RES_FULL) begin
        next_mixed = 2'h0;
      end
    end
    next_neg[0] = (next_idx > `SPC_QUARTER) &&
                  (next_idx < `SPC_HALF_TURN + `SPC_QUARTER);
    next_neg[1] = next_idx > `SPC_HALF_TURN;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx <= `SPC_HOME_IDX;
      neg <= 2'h0;
      mixed <= 2'h3;
    end else begin
      idx <= next_idx;
      neg <= next_neg;
      mixed <= next_mixed;
    end
  end

endmodule : spc_translator
`default_nettype wire

// file: test/spc_ctrl_sva.sv
// Checker on spc_ctrl pins: gating, short latch, chop on-time, APB answer.
// Bound into spc_ctrl; scaled counts come from its parameters.
`timescale 1ns/100ps
`default_nettype none
`include "spc_defines.svh"
module spc_ctrl_sva #(
  parameter int BLANK_CYC = 4,
  parameter int OFF_CYC = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [`SPC_ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic out_disable,
  input wire logic sleep_n,
  input wire logic supply_lockout,
  input wire logic over_temp,
  input wire logic pump_supply_uv,
  input wire logic sink_gate_supply_fault,
  input wire logic [1:0] sense_trip,
  input wire logic [1:0] short_to_ground,
  input wire logic [1:0] zero_current,
  input wire logic [1:0] src_a,
  input wire logic [1:0] snk_a,
  input wire logic [1:0] src_b,
  input wire logic [1:0] snk_b,
  input wire logic pump_enable
);
  localparam int ON_MAX = BLANK_CYC + OFF_CYC * 5 / 16 + 8;
  logic [7:0] g;
  logic [15:0] on_cnt, next_on_cnt;
  logic seen0, next_seen0;
  assign g = {src_a, snk_a, src_b, snk_b};
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Only sleep clears a latched short
  always_comb begin
    next_seen0 = sleep_n && (seen0 || short_to_ground[0]);
    next_on_cnt = (sense_trip[0] && (src_a[0] || src_b[0])) ? on_cnt + 16'h1 : 16'h0;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen0 <= 1'h0;
      on_cnt <= 16'h0;
    end else begin
      seen0 <= next_seen0;
      on_cnt <= next_on_cnt;
    end
  end
  dis_gates_a: assert property (out_disable |=> g == 8'h00)
    else $error("gates on while disabled");
  sleep_off_a: assert property (!sleep_n |=> g == 8'h00 && !pump_enable)
    else $error("gates or pump on in sleep");
  fault_off_a: assert property (over_temp || pump_supply_uv |=> g == 8'h00)
    else $error("gates on during fault");
  sink_gate_a: assert property (sink_gate_supply_fault |=> g == 8'h00)
    else $error("gates on with sink gate fault");
  lock_off_a: assert property (supply_lockout |=> g == 8'h00)
    else $error("gates on during lockout");
  short_latch_a: assert property (seen0 |-> ##2 !(src_a[0] || snk_a[0] || src_b[0] || snk_b[0]))
    else $error("shorted bridge drives");
  chop_on_a: assert property (on_cnt <= 16'(ON_MAX))
    else $error("source held on past trip");
  apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle");
  apb_err_a: assert property (pready |-> pslverr == !(paddr inside {`SPC_REG_CTRL,
      `SPC_REG_STATUS, `SPC_REG_IRQ_STAT, `SPC_REG_IRQ_MASK}))
    else $error("pslverr wrong");
  // Low-side recirculation must stop once the winding current is near zero
  zero_rect_a: assert property (zero_current[1] |=> !(snk_a[1] && snk_b[1]))
    else $error("both sinks on at zero current");
  cover property (seen0);
  cover property (pready && pslverr);
  cover property ($fell(src_a[0]) && sense_trip[0]);
endmodule : spc_ctrl_sva
bind spc_ctrl spc_ctrl_sva #(.BLANK_CYC(BLANK_CYC), .OFF_CYC(OFF_CYC)) spc_ctrl_sva_inst (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .out_disable(out_disable), .sleep_n(sleep_n),
  .supply_lockout(supply_lockout), .over_temp(over_temp), .pump_supply_uv(pump_supply_uv),
  .sink_gate_supply_fault(sink_gate_supply_fault), .sense_trip(sense_trip),
  .short_to_ground(short_to_ground), .zero_current(zero_current), .src_a(src_a),
  .snk_a(snk_a), .src_b(src_b),
  .snk_b(snk_b), .pump_enable(pump_enable)
);
`default_nettype wire

// file: test/spc_ctrl_tb.sv
// Bench for spc_ctrl: registers, interrupt, stepping, gating, short, chop.
// Host model drives sleep and step; counts are scaled down.
`timescale 1ns/100ps
`default_nettype none
`include "spc_defines.svh"
module spc_ctrl_tb;
  logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [`SPC_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, step, sleep_n, busy, pump_enable, irq, err, prev;
  logic dir = 1'h0, out_disable = 1'h0, sleep_req = 1'h1, step_req = 1'h0;
  logic [3:0] flt = '0;
  logic [1:0] res = '0, trip = '0, shrt = '0, zc = '0, src_a, snk_a, src_b, snk_b;
  logic [4:0] pos;
  wire [7:0] gates = {src_a, snk_a, src_b, snk_b};
  int fail_count = 0, n_compared = 0, cyc = 0, cnt;
  always #4 clk = ~clk;
  // Random load current, bridge 0 zero-current flag held low while chopping is counted
  always @(posedge clk) zc <= trip[0] ? {1'($urandom), 1'h0} : 2'($urandom);
  spc_ctrl #(.BLANK_CYC(4), .OFF_CYC(32), .SETTLE_CYC(20)) spc_ctrl_inst (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .step(step), .dir(dir), .step_resolution_select(res), .out_disable(out_disable),
    .sleep_n(sleep_n), .supply_lockout(flt[3]), .over_temp(flt[2]),
    .pump_supply_uv(flt[1]), .sink_gate_supply_fault(flt[0]), .sense_trip(trip),
    .short_to_ground(shrt), .zero_current(zc), .src_a(src_a), .snk_a(snk_a),
    .src_b(src_b), .snk_b(snk_b), .pump_enable(pump_enable), .irq(irq));
  spc_host_model #(.SETTLE_CYC(20)) spc_host_model_inst (
    .clk(clk), .rst_n(rst_n), .sleep_req(sleep_req), .step_req(step_req),
    .sleep_n(sleep_n), .step(step), .busy(busy));
  task automatic check(input string w, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", w, e, s);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [`SPC_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    // Look between edges where pready is settled; the bench timeout ends a hang
    do begin
      @(negedge clk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    @(posedge clk);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic rdchk(input string w, input logic [`SPC_ADDR_W-1:0] a,
                       input logic [31:0] m, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    check(w, e, rd & m);
  endtask : rdchk
  function automatic logic [4:0] nxt(input logic [4:0] p, input logic d, input logic [1:0] r);
    return d ? p + (5'h08 >> r) : p - (5'h08 >> r);
  endfunction : nxt
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(3));
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    apb(1'h1, `SPC_REG_STATUS, 32'hFFFFFFFF);
    rdchk("status", `SPC_REG_STATUS, 32'h1F08, 32'h408);
    apb(1'h0, 12'h010, 32'h0);
    check("slverr", 32'h1, {31'h0, err});
    check("err_data", 32'h0, rd);
    cnt = $urandom % 2;
    apb(1'h1, `SPC_REG_CTRL, cnt);
    rdchk("ctrl", `SPC_REG_CTRL, 32'hFFFFFFFF, cnt);
    apb(1'h1, `SPC_REG_IRQ_MASK, 32'hFF);
    rdchk("mask", `SPC_REG_IRQ_MASK, 32'hFFFFFFFF, 32'h7);
    sleep_req <= 1'h0;
    repeat (40) @(posedge clk);
    rdchk("awake", `SPC_REG_STATUS, 32'h1F18, 32'h410);
    check("irq_on", 32'h1, {31'h0, irq});
    check("pump_on", 32'h1, {31'h0, pump_enable});
    rdchk("irq_stat", `SPC_REG_IRQ_STAT, 32'h7, 32'h4);
    repeat (2) @(posedge clk);
    check("irq_off", 32'h0, {31'h0, irq});
    pos = 5'h04;
    for (int i = 0; i < 8; i++) begin
      dir <= 1'($urandom);
      res <= 2'($urandom);
      out_disable <= i[0];
      step_req <= 1'h1;
      @(posedge clk);
      step_req <= 1'h0;
      repeat (3) @(posedge clk);
      cnt = 0;
      while (busy && cnt < 50) begin
        @(posedge clk);
        cnt++;
      end
      if (i[0]) check("dis_gates", 32'h0, {24'h0, gates});
      pos = nxt(pos, dir, res);
      rdchk("pos", `SPC_REG_STATUS, 32'h1F00, {19'h0, pos, 8'h0});
    end
    out_disable <= 1'h0;
    for (int k = 0; k < 4; k++) begin
      flt <= 4'h8 >> k;
      repeat (3) @(posedge clk);
      check("fault_gates", 32'h0, {24'h0, gates});
      flt <= 4'h0;
      repeat (20) @(posedge clk);
      check("resume", 32'h1, {31'h0, |gates});
    end
    rdchk("home", `SPC_REG_STATUS, 32'h1F00, 32'h400);
    rdchk("fault_irq", `SPC_REG_IRQ_STAT, 32'h2, 32'h2);
    shrt <= 2'h1;
    @(posedge clk);
    shrt <= 2'h0;
    repeat (30) @(posedge clk);
    check("short_gates", 32'h0, {28'h0, src_a[0], snk_a[0], src_b[0], snk_b[0]});
    rdchk("short_flag", `SPC_REG_STATUS, 32'h3, 32'h1);
    sleep_req <= 1'h1;
    repeat (5) @(posedge clk);
    check("pump_off", 32'h0, {31'h0, pump_enable});
    sleep_req <= 1'h0;
    repeat (40) @(posedge clk);
    rdchk("short_clear", `SPC_REG_STATUS, 32'h1F03, 32'h400);
    trip <= 2'h3;
    cnt = 0;
    prev = 1'h1;
    repeat (200) begin
      @(posedge clk);
      if ((src_a[0] || src_b[0]) && !prev) cnt++;
      prev = src_a[0] || src_b[0];
    end
    check("chop_count", 32'h1, {31'h0, cnt >= 4 && cnt <= 6});
    trip <= 2'h0;
    end_of_test();
  end
endmodule : spc_ctrl_tb
`default_nettype wire

// file: test/spc_host_model.sv
// Host stand-in: drives sleep and single step pulses on bench request.
// Assumes requests arrive on clk; SETTLE_CYC matches the controller's.
`timescale 1ns/100ps
`default_nettype none
module spc_host_model #(
  parameter int SETTLE_CYC = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sleep_req,
  input wire logic step_req,
  output logic sleep_n,
  output logic step,
  output logic busy
);
  int hold;
  logic pend;
  logic [1:0] ph;
  assign busy = pend || ph != 2'h0;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_n <= 1'h0;
      step <= 1'h0;
      hold <= 0;
      pend <= 1'h0;
      ph <= 2'h0;
    end else begin
      sleep_n <= !sleep_req;
      // Pump needs time after wake, so steps wait here
      if (!sleep_n) begin
        hold <= SETTLE_CYC + 2;
      end else if (hold > 0) begin
        hold <= hold - 1;
      end
      if (step_req) begin
        pend <= 1'h1;
      end
      if (ph != 2'h0) begin
        ph <= ph + 2'h1;
      end else if (pend && sleep_n && hold == 0) begin
        pend <= 1'h0;
        ph <= 2'h1;
      end
      step <= ph == 2'h1 || ph == 2'h2;
    end
  end
endmodule : spc_host_model
`default_nettype wire
